// *** src/dgpio_map.svh ***
// Register indices, reset values and bit positions of the dual port block
`ifndef DGPIO_MAP_SVH
`define DGPIO_MAP_SVH

// Register indices; the byte address is four times the index
`define DGPIO_IDX_C_LATCH 8'h07
`define DGPIO_IDX_D_LATCH 8'h08
`define DGPIO_IDX_C_DIR 8'h87
`define DGPIO_IDX_D_DIR 8'h88
`define DGPIO_IDX_E_CTRL 8'h89
`define DGPIO_IDX_IRQ_STAT 8'h90
`define DGPIO_IDX_IRQ_MASK 8'h91

// Reset values
`define DGPIO_DIR_RESET 8'hff
`define DGPIO_E_DIR_RESET 3'h7
`define DGPIO_IRQ_RESET 3'h0

// Fields of the fifth port direction and slave control register
`define DGPIO_E_WAITING 7
`define DGPIO_E_PENDING 6
`define DGPIO_E_OVERFLOW 5
`define DGPIO_E_SELECT 4

// First port pin owners
`define DGPIO_PIN_TIMER 0
`define DGPIO_PIN_SECOND_CAPTURE_COMPARE_PWM 1
`define DGPIO_PIN_FIRST_CAPTURE_COMPARE_PWM 2
`define DGPIO_PIN_SSP_CLK 3
`define DGPIO_PIN_SSP_DIN 4
`define DGPIO_PIN_SSP_DOUT 5
`define DGPIO_PIN_USART_TX 6
`define DGPIO_PIN_USART_RX 7

// Interrupt status bits
`define DGPIO_IRQ_RX 0
`define DGPIO_IRQ_TX 1
`define DGPIO_IRQ_OVF 2

// Bus responses
`define DGPIO_RESP_OKAY 2'h0
`define DGPIO_RESP_SLVERR 2'h2

`endif

// *** src/dgpio_pkg.sv ***
// Types shared by the dual port block
package dgpio_pkg;

  // Requests from the on-chip peripherals sharing the first port
  typedef struct packed {
    logic timer_osc_en;        // Timer oscillator / external clock on bit 0
    logic second_ccp_en;       // Second capture/compare/PWM on bit 1
    logic first_ccp_en;        // First capture/compare/PWM on bit 2
    logic serial_unit_en;      // Synchronous serial unit on bits 3..5
    logic usart_en;            // USART on bits 6..7
    logic [7:0] out;           // Peripheral output value per pin
    logic [7:0] oe;            // Peripheral output enable per pin
  } dgpio_periph_t;

  // Parallel slave port strobes from the external processor, active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } dgpio_psp_ctrl_t;

  // Bus channel states
  typedef enum logic {wr_collect, wr_respond} dgpio_wr_state_t;
  typedef enum logic {rd_collect, rd_respond} dgpio_rd_state_t;

endpackage

// *** src/dgpio_top.sv ***
// Dual 8-bit general purpose port with peripheral override and parallel slave port
// Notes on behaviour
// - First port 8 bits; direction 1 means input
// - Direction 0 drives output latch onto pin
// - Enabled peripheral overrides pin direction bit
// - Select steers latch or peripheral output
// - Peripheral enable acts only while selected
// - Bit 3 serial clock, bit 4 serial data
// - Bits 6,7 carry USART transmit and receive
// - Bit 2 first, bit 1 second capture/compare
// - Bit 5 carries serial data output
// - Bit 0 timer oscillator or clock input
// - Second port 8 bits, per-pin direction
// - Select bit turns second port into slave
// - Reset: second port direction all ones
// - External read strobe puts latch on pins
// - Write onto unread word sets sticky overflow
`timescale 1ns/1ps
`include "dgpio_map.svh"

module dgpio_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  input wire dgpio_pkg::dgpio_periph_t periph,
  output logic [7:0] periph_pin_in,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  input wire dgpio_pkg::dgpio_psp_ctrl_t psp_ctrl,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  dgpio_pkg::dgpio_wr_state_t wr_state; // Write channel state
  dgpio_pkg::dgpio_rd_state_t rd_state; // Read channel state
  logic aw_held, w_held; // Address / data taken, not yet used
  logic [ADDR_W-1:0] aw_addr; // Held write address
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held byte enables
  logic [7:0] wr_idx; // Register index of the held write
  logic wr_hit; // Held write targets a mapped register
  logic do_write; // One-cycle register update strobe
  logic [7:0] rd_idx; // Register index of the read request
  logic rd_take; // Read request taken this cycle
  logic [7:0] c_latch, d_latch; // Third / fourth port output latches
  logic [7:0] c_dir, d_dir; // Third / fourth port direction, 1 = input
  logic [2:0] e_dir; // Fifth port direction bits
  logic slave_port_select; // Fourth port in slave mode
  logic input_word_waiting; // Received word not yet read
  logic output_word_pending; // Written word not yet fetched
  logic input_overflow_flag; // Write arrived over unread word
  logic [7:0] in_word; // Word received from the processor
  logic [7:0] in_capture; // Bus sampled during the strobe
  logic [7:0] c_s1, c_s2, d_s1, d_s2; // Pin synchronisers, two stages each
  dgpio_pkg::dgpio_psp_ctrl_t ctl_s1, ctl_s2; // Strobe synchronisers
  logic psp_wr_act, psp_rd_act; // External write / read strobe active
  logic psp_wr_prev, psp_rd_prev; // Previous strobe levels for edges
  logic psp_wr_end, psp_rd_end; // Write / read strobe just released
  logic [7:0] pin_sel; // Peripheral owns the pin
  logic [2:0] irq_status; // Sticky event bits
  logic [2:0] irq_mask; // Interrupt enables
  logic [2:0] irq_set, irq_clr; // Events and write-one-to-clear this cycle

  //////////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  // True for a mapped, aligned word; high or misaligned addresses miss
  function automatic logic decode(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) && (a[9:2] inside {`DGPIO_IDX_C_LATCH, `DGPIO_IDX_D_LATCH,
      `DGPIO_IDX_C_DIR, `DGPIO_IDX_D_DIR, `DGPIO_IDX_E_CTRL, `DGPIO_IDX_IRQ_STAT, `DGPIO_IDX_IRQ_MASK});
  endfunction

  assign wr_idx = aw_addr[9:2];
  assign wr_hit = decode(aw_addr);
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_take = s_axi_arvalid && s_axi_arready;
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign do_write = (wr_state == dgpio_pkg::wr_collect) && aw_held && w_held && wr_hit && w_strb[0];

  //////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= dgpio_pkg::wr_collect;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DGPIO_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      case (wr_state)
        dgpio_pkg::wr_collect: begin
          if (s_axi_awvalid && s_axi_awready) begin // Address channel
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
          end else if (!aw_held) begin
            s_axi_awready <= 1'b1;
          end
          if (s_axi_wvalid && s_axi_wready) begin // Data channel
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
          end else if (!w_held) begin
            s_axi_wready <= 1'b1;
          end
          // Both present: register update and response both land on the next edge
          if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DGPIO_RESP_OKAY : `DGPIO_RESP_SLVERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_state <= dgpio_pkg::wr_respond;
          end
        end
        dgpio_pkg::wr_respond: begin
          // Ready lines reopen only after the response is taken
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state <= dgpio_pkg::wr_collect;
          end
        end
        default: begin
          wr_state <= dgpio_pkg::wr_collect;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel: value sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= dgpio_pkg::rd_collect;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DGPIO_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      case (rd_state)
        dgpio_pkg::rd_collect: begin
          if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= decode(s_axi_araddr) ? `DGPIO_RESP_OKAY : `DGPIO_RESP_SLVERR;
            s_axi_rdata <= decode(s_axi_araddr) ? read_value(rd_idx) : 32'h0000_0000;
            rd_state <= dgpio_pkg::rd_respond;
          end else begin
            s_axi_arready <= 1'b1;
          end
        end
        dgpio_pkg::rd_respond: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state <= dgpio_pkg::rd_collect;
          end
        end
        default: begin
          rd_state <= dgpio_pkg::rd_collect;
        end
      endcase
    end
  end
  // Read data; port latches read back the pin levels, as software expects
  function automatic logic [31:0] read_value(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      `DGPIO_IDX_C_LATCH: v[7:0] = c_s2;
      // In slave mode the processor's word is returned instead of the pins
      `DGPIO_IDX_D_LATCH: v[7:0] = slave_port_select ? in_word : d_s2;
      `DGPIO_IDX_C_DIR: v[7:0] = c_dir;
      `DGPIO_IDX_D_DIR: v[7:0] = d_dir;
      `DGPIO_IDX_E_CTRL: begin
        v[2:0] = e_dir;
        v[`DGPIO_E_SELECT] = slave_port_select;
        v[`DGPIO_E_OVERFLOW] = input_overflow_flag;
        v[`DGPIO_E_PENDING] = output_word_pending;
        v[`DGPIO_E_WAITING] = input_word_waiting;
      end
      `DGPIO_IDX_IRQ_STAT: v[2:0] = irq_status;
      `DGPIO_IDX_IRQ_MASK: v[2:0] = irq_mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Output latches: no reset, so power-on leaves them unknown and later resets keep them
  always_ff @(posedge aclk) begin
    if (do_write && wr_idx == `DGPIO_IDX_C_LATCH) begin
      c_latch <= w_data[7:0];
    end
    if (do_write && wr_idx == `DGPIO_IDX_D_LATCH) begin
      d_latch <= w_data[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Direction registers; overrides never touch the stored bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_dir <= `DGPIO_DIR_RESET;
      d_dir <= `DGPIO_DIR_RESET;
    end else begin
      // Stored value is software's alone, so a plain write restores it
      if (do_write && wr_idx == `DGPIO_IDX_C_DIR) begin
        c_dir <= w_data[7:0];
      end
      if (do_write && wr_idx == `DGPIO_IDX_D_DIR) begin
        d_dir <= w_data[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fifth port control: direction bits and the slave mode select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_dir <= `DGPIO_E_DIR_RESET;
      slave_port_select <= 1'b0;
    end else if (do_write && wr_idx == `DGPIO_IDX_E_CTRL) begin
      e_dir <= w_data[2:0];
      slave_port_select <= w_data[`DGPIO_E_SELECT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read by logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_s1 <= 8'h00;
      c_s2 <= 8'h00;
      d_s1 <= 8'h00;
      d_s2 <= 8'h00;
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
      psp_wr_prev <= 1'b0;
      psp_rd_prev <= 1'b0;
      periph_pin_in <= 8'h00;
    end else begin
      c_s1 <= port_c_in;
      c_s2 <= c_s1;
      d_s1 <= port_d_in;
      d_s2 <= d_s1;
      ctl_s1 <= psp_ctrl;
      ctl_s2 <= ctl_s1;
      psp_wr_prev <= psp_wr_act;
      psp_rd_prev <= psp_rd_act;
      periph_pin_in <= c_s2; // Capture, clock and receive inputs
    end
  end

  // Strobes count only in slave mode and with chip select low
  assign psp_wr_act = slave_port_select && !ctl_s2.cs_n && !ctl_s2.wr_n;
  assign psp_rd_act = slave_port_select && !ctl_s2.cs_n && !ctl_s2.rd_n;
  assign psp_wr_end = psp_wr_prev && !psp_wr_act;
  assign psp_rd_end = psp_rd_prev && !psp_rd_act;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel slave port handshake flags
  // Bus sampled under the strobe, committed at release, as data may move then
  always_ff @(posedge aclk) begin
    if (psp_wr_act) begin
      in_capture <= d_s2;
    end
    if (psp_wr_end) begin
      in_word <= in_capture;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_word_waiting <= 1'b0;
      output_word_pending <= 1'b0;
      input_overflow_flag <= 1'b0;
    end else begin
      // New word wins over a software read in the same cycle
      if (psp_wr_end) begin
        input_word_waiting <= 1'b1;
      end else if (rd_take && decode(s_axi_araddr) && rd_idx == `DGPIO_IDX_D_LATCH) begin
        input_word_waiting <= 1'b0;
      end
      // Software write marks a word for the processor; its read fetches it
      if (do_write && wr_idx == `DGPIO_IDX_D_LATCH && slave_port_select) begin
        output_word_pending <= 1'b1;
      end else if (psp_rd_end) begin
        output_word_pending <= 1'b0;
      end
      // Sticky; only software clears it by writing zero, a new event wins
      if (psp_wr_end && input_word_waiting) begin
        input_overflow_flag <= 1'b1;
      end else if (do_write && wr_idx == `DGPIO_IDX_E_CTRL && !w_data[`DGPIO_E_OVERFLOW]) begin
        input_overflow_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Third port pin owners
  // Each peripheral owns its pins only while enabled
  always_comb begin
    pin_sel = 8'h00;
    pin_sel[`DGPIO_PIN_TIMER] = periph.timer_osc_en;
    pin_sel[`DGPIO_PIN_SECOND_CAPTURE_COMPARE_PWM] = periph.second_ccp_en;
    pin_sel[`DGPIO_PIN_FIRST_CAPTURE_COMPARE_PWM] = periph.first_ccp_en;
    pin_sel[`DGPIO_PIN_SSP_CLK] = periph.serial_unit_en;
    pin_sel[`DGPIO_PIN_SSP_DIN] = periph.serial_unit_en;
    pin_sel[`DGPIO_PIN_SSP_DOUT] = periph.serial_unit_en;
    pin_sel[`DGPIO_PIN_USART_TX] = periph.usart_en;
    pin_sel[`DGPIO_PIN_USART_RX] = periph.usart_en;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one slice per bit
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Third port: peripheral or latch, peripheral enable or direction bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port_c_out[i] <= 1'b0;
          port_c_oe[i] <= 1'b0;
        end else if (pin_sel[i]) begin
          port_c_out[i] <= periph.out[i];
          port_c_oe[i] <= periph.oe[i];
        end else begin
          port_c_out[i] <= c_latch[i];
          port_c_oe[i] <= !c_dir[i];
        end
      end
      // Fourth port: slave mode hands the driver to the read strobe
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port_d_out[i] <= 1'b0;
          port_d_oe[i] <= 1'b0;
        end else begin
          port_d_out[i] <= d_latch[i];
          port_d_oe[i] <= slave_port_select ? psp_rd_act : !d_dir[i];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output
  always_comb begin
    irq_set = 3'h0;
    irq_set[`DGPIO_IRQ_RX] = psp_wr_end;
    irq_set[`DGPIO_IRQ_TX] = psp_rd_end;
    irq_set[`DGPIO_IRQ_OVF] = psp_wr_end && input_word_waiting;
    irq_clr = (do_write && wr_idx == `DGPIO_IDX_IRQ_STAT) ? w_data[2:0] : 3'h0;
  end

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `DGPIO_IRQ_RESET;
      irq_mask <= `DGPIO_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (do_write && wr_idx == `DGPIO_IDX_IRQ_MASK) begin
        irq_mask <= w_data[2:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// *** dv/dgpio_top_sva.sv ***
// Checker for reset state and peripheral ownership of the third port pins
`timescale 1ns/1ps
module dgpio_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dgpio_pkg::dgpio_periph_t periph,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] port_c_out,
  input wire logic [7:0] port_c_oe,
  input wire logic [7:0] port_d_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic any_en; // Some peripheral claims a pin; the five enables lead the struct
  assign any_en = |periph[20:16];
  ////////////////////////////////////////////////////////////////////////
  // After reset every pin floats until software or a peripheral drives it
  property p_c_reset;
    $rose(aresetn) && !any_en |=> port_c_oe == 8'h00;
  endproperty
  a_c_reset: assert property (p_c_reset) else $error("third port driven after reset");
  property p_d_reset;
    $rose(aresetn) |=> port_d_oe == 8'h00;
  endproperty
  a_d_reset: assert property (p_d_reset) else $error("fourth port driven after reset");
  ////////////////////////////////////////////////////////////////////////
  // An enabled peripheral owns its pins one cycle later
  property p_timer;
    periph.timer_osc_en |=> port_c_oe[0] == $past(periph.oe[0]) && port_c_out[0] == $past(periph.out[0]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer pin not handed over");
  property p_second_capture_compare_pwm;
    periph.second_ccp_en ##1 1'b1 |-> {port_c_oe[1], port_c_out[1]} == $past({periph.oe[1], periph.out[1]});
  endproperty
  a_second_capture_compare_pwm: assert property (p_second_capture_compare_pwm) else $error("second compare pin not handed over");
  property p_first_capture_compare_pwm;
    periph.first_ccp_en |=> port_c_oe[2] == $past(periph.oe[2]) && port_c_out[2] == $past(periph.out[2]);
  endproperty
  a_first_capture_compare_pwm: assert property (p_first_capture_compare_pwm) else $error("first compare pin not handed over");
  property p_serial;
    periph.serial_unit_en [*2] |-> port_c_oe[5:3] == $past(periph.oe[5:3]) && port_c_out[5:3] == $past(periph.out[5:3]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial pins not handed over");
  property p_usart;
    periph.usart_en |=> port_c_oe[7:6] == $past(periph.oe[7:6]) && port_c_out[7:6] == $past(periph.out[7:6]);
  endproperty
  a_usart: assert property (p_usart) else $error("usart pins not handed over");
  // Without the USART select, its peripheral enables must not reach the bit 6 and 7 drivers
  property p_not_sel;
    !periph.usart_en && !$past(periph.usart_en) && !s_axi_bvalid |=> $stable(port_c_oe[7:6]);
  endproperty
  a_not_sel: assert property (p_not_sel) else $error("unselected peripheral moved the driver");
endmodule
bind dgpio_top dgpio_top_sva i_sva (.aclk(aclk), .aresetn(aresetn), .periph(periph), .s_axi_bvalid(s_axi_bvalid),
  .port_c_out(port_c_out), .port_c_oe(port_c_oe), .port_d_oe(port_d_oe));

// *** dv/dgpio_ext_host.sv ***
// External processor model on the fourth port in slave mode
`timescale 1ns/1ps
module dgpio_ext_host (
  input wire logic aclk,
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] port_d_oe,
  output logic [7:0] port_d_in,
  output dgpio_pkg::dgpio_psp_ctrl_t psp_ctrl
);
  logic [7:0] bus_drv = 8'h00; // Host data on the lines
  logic drive = 1'b0; // Host owns the lines
  // Released lines show the inverse, so stale data never passes for valid
  assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & (drive ? bus_drv : ~bus_drv));
  initial psp_ctrl = 3'b111;
  ////////////////////////////////////////////////////////////////////////
  // Strobed write, held well past the two-flop synchronisers
  task automatic host_write(input logic [7:0] d);
    @(posedge aclk);
    bus_drv <= d;
    drive <= 1'b1;
    psp_ctrl <= 3'b010;
    repeat (5) @(posedge aclk);
    psp_ctrl <= 3'b111;
    repeat (2) @(posedge aclk);
    drive <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // Strobed read; the block must drive the lines meanwhile
  task automatic host_read(output logic [7:0] d, output logic [7:0] oe);
    @(posedge aclk);
    psp_ctrl <= 3'b001;
    repeat (6) @(posedge aclk);
    d = port_d_in;
    oe = port_d_oe;
    psp_ctrl <= 3'b111;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// *** dv/dgpio_tb_top.sv ***
// Self-checking testbench for the dual port block
`timescale 1ns/1ps
`include "dgpio_map.svh"
module dgpio_tb_top;
  localparam int LIMIT = 20000; // Cycle ceiling, far above the run
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port_c_in, port_c_out, port_c_oe, periph_pin_in, port_d_in, port_d_out, port_d_oe;
  logic [7:0] c_ext = 8'h00; // Outside level on undriven third port pins
  dgpio_pkg::dgpio_periph_t periph = '0;
  dgpio_pkg::dgpio_psp_ctrl_t psp_ctrl;
  int n_fail = 0, n_checks = 0, cycles = 0;
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & c_ext);
  always #4 aclk = ~aclk;
  dgpio_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_c_in, .port_c_out, .port_c_oe,
    .periph, .periph_pin_in, .port_d_in, .port_d_out, .port_d_oe, .psp_ctrl, .irq);
  dgpio_ext_host i_host (.aclk, .port_d_out, .port_d_oe, .port_d_in, .psp_ctrl);
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Bus write by register index; each channel dropped when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `DGPIO_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", 8'(er), 8'(s_axi_bresp));
  endtask
  // Bus read by register index, compared on the spot
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = `DGPIO_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rdata", exp, s_axi_rdata[7:0]);
    check("rresp", 8'(er), 8'(s_axi_rresp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`DGPIO_IDX_C_DIR, 8'hff);
    rd(`DGPIO_IDX_D_DIR, 8'hff);
    rd(`DGPIO_IDX_E_CTRL, 8'h07);
    rd(`DGPIO_IDX_IRQ_STAT, 8'h00);
    rd(8'h50, 8'h00, `DGPIO_RESP_SLVERR);
    wr(8'h50, 8'hff, `DGPIO_RESP_SLVERR);
  endtask
  // Mixed directions, pins read back through the synchronisers
  task automatic t_port_c();
    c_ext <= 8'h3c;
    wr(`DGPIO_IDX_C_LATCH, 8'ha5);
    wr(`DGPIO_IDX_C_DIR, 8'h0f); // Whole-byte write only
    repeat (2) @(posedge aclk);
    check("c_oe", 8'hf0, port_c_oe);
    check("c_out", 8'ha5, port_c_out);
    rd(`DGPIO_IDX_C_LATCH, 8'hac);
    check("pin_in", 8'hac, periph_pin_in);
  endtask
  // Each peripheral in turn takes only its own pins
  task automatic t_override();
    logic [7:0] m [5] = '{8'h01, 8'h02, 8'h04, 8'h38, 8'hc0};
    for (int k = 0; k < 5; k++) begin
      @(posedge aclk);
      periph <= {5'h10 >> k, 8'h5a, 8'hc3};
      repeat (3) @(posedge aclk);
      check("c_oe", (8'hc3 & m[k]) | (8'hf0 & ~m[k]), port_c_oe);
      check("c_out", (8'h5a & m[k]) | (8'ha5 & ~m[k]), port_c_out);
    end
    periph <= '0;
    rd(`DGPIO_IDX_C_DIR, 8'h0f);
  endtask
  task automatic t_port_d();
    wr(`DGPIO_IDX_D_LATCH, 8'h3c);
    wr(`DGPIO_IDX_D_DIR, 8'h0f);
    repeat (2) @(posedge aclk);
    check("d_oe", 8'hf0, port_d_oe);
    check("d_out", 8'h30, port_d_out & 8'hf0);
  endtask
  // Slave port: fetch, receive, overflow and the interrupt around them
  task automatic t_slave();
    logic [7:0] d, oe;
    wr(`DGPIO_IDX_E_CTRL, 8'h17);
    wr(`DGPIO_IDX_D_LATCH, 8'hc3);
    rd(`DGPIO_IDX_E_CTRL, 8'h57);
    i_host.host_read(d, oe);
    check("psp_oe", 8'hff, oe);
    check("psp_data", 8'hc3, d);
    rd(`DGPIO_IDX_E_CTRL, 8'h17);
    i_host.host_write(8'h5a);
    rd(`DGPIO_IDX_E_CTRL, 8'h97);
    rd(`DGPIO_IDX_D_LATCH, 8'h5a);
    i_host.host_write(8'h66);
    i_host.host_write(8'h77);
    rd(`DGPIO_IDX_E_CTRL, 8'hb7);
    check("irq", 8'h00, 8'(irq));
    rd(`DGPIO_IDX_IRQ_STAT, 8'h07);
    wr(`DGPIO_IDX_IRQ_MASK, 8'h04);
    repeat (2) @(posedge aclk);
    check("irq", 8'h01, 8'(irq));
    wr(`DGPIO_IDX_E_CTRL, 8'h37);
    rd(`DGPIO_IDX_E_CTRL, 8'hb7);
    wr(`DGPIO_IDX_E_CTRL, 8'h17);
    rd(`DGPIO_IDX_E_CTRL, 8'h97);
    wr(`DGPIO_IDX_IRQ_STAT, 8'h07);
    repeat (2) @(posedge aclk);
    check("irq", 8'h00, 8'(irq));
  endtask
  // Second reset: directions back to input, latch kept
  task automatic t_rerst();
    wr(`DGPIO_IDX_C_DIR, 8'h00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("c_oe", 8'h00, port_c_oe);
    check("d_oe", 8'h00, port_d_oe);
    rd(`DGPIO_IDX_E_CTRL, 8'h07);
    wr(`DGPIO_IDX_C_DIR, 8'h00);
    repeat (2) @(posedge aclk);
    check("c_out", 8'ha5, port_c_out);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port_c();
    t_override();
    t_port_d();
    t_slave();
    t_rerst();
    final_report();
  end
endmodule
